// file: hw/mbw_pkg.sv
// shared constants and functions for the modbus block-write link
package mbw_pkg;

    // station addressing
    localparam logic [7:0] MBW_BCAST = 8'h00;
    localparam logic [7:0] MBW_ADDR_MAX = 8'hf7;

    // function and exception codes
    localparam logic [7:0] FC_WMULT = 8'h10;
    localparam logic [7:0] FC_RWMULT = 8'h17;
    localparam logic [7:0] FC_EXC_BIT = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_NONE = 8'h00;

    // register address fields
    localparam int TYP_HI = 15;
    localparam int TYP_LO = 14;
    localparam int IDX_W = 14;
    localparam logic [1:0] TYP_I16 = 2'b00;
    localparam logic [1:0] TYP_I32 = 2'b01;
    localparam logic [1:0] TYP_F32 = 2'b10;
    localparam logic [1:0] TYP_RSVD = 2'b11;

    // request byte offsets
    localparam int OFS_ADDR = 0;
    localparam int OFS_FC = 1;
    localparam int OFS_START = 2;
    localparam int OFS_CNT = 4;
    localparam int OFS_WSTART = 6;
    localparam int OFS_WCNT = 8;
    localparam int OFS_WM_BC = 6;
    localparam int OFS_RW_BC = 10;
    localparam int WM_HDR = 7;
    localparam int RW_HDR = 11;
    localparam int CRC_LEN = 2;
    localparam int MIN_LEN = 4;

    // reply byte offsets and lengths
    localparam int RSP_BC = 2;
    localparam int RSP_HDR = 3;
    localparam int EXC_LEN = 3;
    localparam int WM_RSP_LEN = 6;

    // frame check
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    // master response timeout
    localparam int CLK_HZ = 10000000;
    localparam int RSP_TIMEOUT_MS = 50;
    localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_MS * (CLK_HZ / 1000);

    function automatic logic [15:0] mbw_crc(input logic [15:0] c,
                                           input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic mbw_wide(input logic [1:0] t);
        return t != TYP_I16;
    endfunction

    function automatic logic mbw_typ_bad(input logic [1:0] t,
                                        input logic float_en);
        return (t == TYP_RSVD) || (t == TYP_F32 && !float_en);
    endfunction

endpackage

// file: hw/mbw_if.sv
// byte-stream link between the master and the slave end
`timescale 1ns/1ps
interface mbw_if;
    logic req_valid;
    logic [7:0] req_data;
    logic req_end;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_end;

    modport slave
    (
        input req_valid, req_data, req_end,
        output rsp_valid, rsp_data, rsp_end
    );

    modport master
    (
        output req_valid, req_data, req_end,
        input rsp_valid, rsp_data, rsp_end
    );
endinterface

// file: hw/mbw_slave.sv
// slave end: block write and read/write frame handling with type select
`timescale 1ns/1ps
module mbw_slave
    import mbw_pkg::*;
#(
    parameter int MAX_WR = 16,
    parameter int MAX_RD = 16,
    parameter bit FLOAT_EN = 1'b1
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // serial link
    mbw_if.slave link,
    // station address
    input wire logic [7:0] own_addr_i,
    // parameter write port
    output logic wr_valid_o,
    output logic [13:0] wr_index_o,
    output logic [1:0] wr_type_o,
    output logic [31:0] wr_data_o,
    input wire logic wr_ok_i,
    // parameter read port
    output logic [13:0] rd_index_o,
    output logic [1:0] rd_type_o,
    input wire logic [31:0] rd_data_i
);

    ////////////////////////////////////////////////////////////////////////
    localparam int RXD = RW_HDR + 2 * MAX_WR + CRC_LEN;
    localparam int TXD = RSP_HDR + 2 * MAX_RD;

    typedef enum logic [2:0]
    {
        S_IDLE = 3'b000,
        S_CHECK = 3'b001,
        S_WRITE = 3'b011,
        S_READ = 3'b010,
        S_SEND = 3'b110
    } mbw_sst_e;

    typedef struct packed
    {
        mbw_sst_e st;
        logic [RXD-1:0][7:0] rx;
        logic [7:0] rx_len;
        logic ovf;
        logic [15:0] crc;
        logic [TXD-1:0][7:0] tx;
        logic [7:0] tx_len;
        logic [7:0] tx_ptr;
        logic [7:0] ptr;
        logic [13:0] idx;
        logic [1:0] typ;
        logic [15:0] left;
        logic [15:0] done;
        logic stop;
        logic bcast;
        logic wr_valid;
        logic [31:0] wr_data;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_end;
    } mbw_sstate_s;

    mbw_sstate_s s_q;
    mbw_sstate_s s_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [7:0] fc;
        logic [7:0] bc;
        logic [7:0] exc;
        logic [15:0] wst;
        logic [15:0] wcnt;
        logic [15:0] rst;
        logic [15:0] rcnt;
        logic [8:0] hdr;
        logic wm;
        logic rw;
        logic wide;
        s_d = s_q;
        fc = s_q.rx[OFS_FC];
        wm = fc == FC_WMULT;
        rw = fc == FC_RWMULT;
        rst = {s_q.rx[OFS_START], s_q.rx[OFS_START+1]};
        rcnt = {s_q.rx[OFS_CNT], s_q.rx[OFS_CNT+1]};
        // field positions differ between the two functions
        wst = wm ? rst : {s_q.rx[OFS_WSTART], s_q.rx[OFS_WSTART+1]};
        wcnt = wm ? rcnt : {s_q.rx[OFS_WCNT], s_q.rx[OFS_WCNT+1]};
        bc = wm ? s_q.rx[OFS_WM_BC] : s_q.rx[OFS_RW_BC];
        hdr = wm ? 9'(WM_HDR) : 9'(RW_HDR);
        wide = mbw_wide(s_q.typ);
        exc = EXC_NONE;
        s_d.wr_valid = 1'b0;
        s_d.rsp_valid = 1'b0;
        s_d.rsp_end = 1'b0;
        unique case (s_q.st)
        S_IDLE:
        begin
            if (link.req_valid)
            begin
                // overlong frames are flagged, never wrapped into the buffer
                if (s_q.rx_len == 8'(RXD))
                    s_d.ovf = 1'b1;
                else
                begin
                    s_d.rx[s_q.rx_len] = link.req_data;
                    s_d.rx_len = s_q.rx_len + 8'h01;
                end
                s_d.crc = mbw_crc(s_q.crc, link.req_data);
            end
            if (link.req_end)
                s_d.st = S_CHECK;
        end
        S_CHECK:
        begin
            s_d.rx_len = '0;
            s_d.ovf = 1'b0;
            s_d.crc = CRC_INIT;
            s_d.tx_ptr = '0;
            s_d.st = S_IDLE;
            s_d.bcast = s_q.rx[OFS_ADDR] == MBW_BCAST;
            s_d.tx[OFS_ADDR] = own_addr_i;
            s_d.tx[OFS_FC] = fc;
            if (s_q.ovf || s_q.crc != CRC_GOOD
                || s_q.rx_len < 8'(MIN_LEN)
                || !(s_d.bcast || s_q.rx[OFS_ADDR] == own_addr_i))
                s_d.st = S_IDLE;
            else if (!wm && !rw)
                exc = EXC_FUNC;
            else if (wcnt > 16'(MAX_WR))
                s_d.st = S_IDLE;
            else if ({1'b0, s_q.rx_len} != hdr + {1'b0, bc} + 9'(CRC_LEN))
                s_d.st = S_IDLE;
            else if (mbw_typ_bad(wst[TYP_HI:TYP_LO], FLOAT_EN)
                || (rw && mbw_typ_bad(rst[TYP_HI:TYP_LO], FLOAT_EN))
                || {8'h00, bc} != (wcnt << 1)
                || (mbw_wide(wst[TYP_HI:TYP_LO]) && wcnt[0])
                || (rw && mbw_wide(rst[TYP_HI:TYP_LO]) && rcnt[0])
                || (rw && rcnt > 16'(MAX_RD)))
                exc = EXC_ADDR;
            else
            begin
                s_d.st = S_WRITE;
                s_d.idx = wst[IDX_W-1:0];
                s_d.typ = wst[TYP_HI:TYP_LO];
                s_d.left = mbw_wide(wst[TYP_HI:TYP_LO]) ? wcnt >> 1 : wcnt;
                s_d.ptr = hdr[7:0];
                s_d.done = '0;
                s_d.stop = 1'b0;
            end
            if (exc != EXC_NONE)
            begin
                s_d.tx[OFS_FC] = fc | FC_EXC_BIT;
                s_d.tx[RSP_BC] = exc;
                s_d.tx_len = 8'(EXC_LEN);
                s_d.st = s_d.bcast ? S_IDLE : S_SEND;
            end
        end
        S_WRITE:
        begin
            // the write port answers in the same cycle as the strobe
            if (s_q.wr_valid)
            begin
                if (wr_ok_i)
                    s_d.done = s_q.done + (wide ? 16'h0002 : 16'h0001);
                else
                    s_d.stop = 1'b1;
                s_d.idx = s_q.idx + 14'h0001;
                s_d.left = s_q.left - 16'h0001;
                s_d.ptr = s_q.ptr + (wide ? 8'h04 : 8'h02);
            end
            else if (s_q.left == '0 || s_q.stop)
            begin
                if (s_q.bcast)
                    s_d.st = S_IDLE;
                else if (wm)
                begin
                    s_d.tx[OFS_START] = wst[15:8];
                    s_d.tx[OFS_START+1] = wst[7:0];
                    s_d.tx[OFS_CNT] = s_q.done[15:8];
                    s_d.tx[OFS_CNT+1] = s_q.done[7:0];
                    s_d.tx_len = 8'(WM_RSP_LEN);
                    s_d.st = S_SEND;
                end
                else
                begin
                    s_d.idx = rst[IDX_W-1:0];
                    s_d.typ = rst[TYP_HI:TYP_LO];
                    s_d.left = mbw_wide(rst[TYP_HI:TYP_LO]) ? rcnt >> 1 : rcnt;
                    s_d.tx[RSP_BC] = {rcnt[6:0], 1'b0};
                    s_d.tx_len = 8'(RSP_HDR);
                    s_d.st = S_READ;
                end
            end
            else
            begin
                s_d.wr_valid = 1'b1;
                if (wide)
                    s_d.wr_data = {s_q.rx[s_q.ptr], s_q.rx[s_q.ptr+8'h01],
                        s_q.rx[s_q.ptr+8'h02], s_q.rx[s_q.ptr+8'h03]};
                else
                    s_d.wr_data = {{16{s_q.rx[s_q.ptr][7]}}, s_q.rx[s_q.ptr],
                        s_q.rx[s_q.ptr+8'h01]};
            end
        end
        S_READ:
        begin
            if (s_q.left == '0)
                s_d.st = S_SEND;
            else
            begin
                if (wide)
                begin
                    s_d.tx[s_q.tx_len] = rd_data_i[31:24];
                    s_d.tx[s_q.tx_len+8'h01] = rd_data_i[23:16];
                    s_d.tx[s_q.tx_len+8'h02] = rd_data_i[15:8];
                    s_d.tx[s_q.tx_len+8'h03] = rd_data_i[7:0];
                    s_d.tx_len = s_q.tx_len + 8'h04;
                end
                else
                begin
                    s_d.tx[s_q.tx_len] = rd_data_i[15:8];
                    s_d.tx[s_q.tx_len+8'h01] = rd_data_i[7:0];
                    s_d.tx_len = s_q.tx_len + 8'h02;
                end
                s_d.idx = s_q.idx + 14'h0001;
                s_d.left = s_q.left - 16'h0001;
            end
        end
        S_SEND:
        begin
            s_d.rsp_valid = 1'b1;
            s_d.tx_ptr = s_q.tx_ptr + 8'h01;
            if (s_q.tx_ptr < s_q.tx_len)
            begin
                s_d.rsp_data = s_q.tx[s_q.tx_ptr];
                s_d.crc = mbw_crc(s_q.crc, s_q.tx[s_q.tx_ptr]);
            end
            else if (s_q.tx_ptr == s_q.tx_len)
                s_d.rsp_data = s_q.crc[7:0];
            else if (s_q.tx_ptr == s_q.tx_len + 8'h01)
                s_d.rsp_data = s_q.crc[15:8];
            else
            begin
                s_d.rsp_valid = 1'b0;
                s_d.rsp_end = 1'b1;
                s_d.tx_ptr = '0;
                s_d.crc = CRC_INIT;
                s_d.st = S_IDLE;
            end
        end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
            s_q.crc <= CRC_INIT;
        end
        else
            s_q <= s_d;
    end

    assign link.rsp_valid = s_q.rsp_valid;
    assign link.rsp_data = s_q.rsp_data;
    assign link.rsp_end = s_q.rsp_end;
    assign wr_valid_o = s_q.wr_valid;
    assign wr_index_o = s_q.idx;
    assign wr_type_o = s_q.typ;
    assign wr_data_o = s_q.wr_data;
    assign rd_index_o = s_q.idx;
    assign rd_type_o = s_q.typ;

endmodule

// file: hw/mbw_master.sv
// master end: builds block write and read/write requests, collects replies
`timescale 1ns/1ps
module mbw_master
    import mbw_pkg::*;
#(
    parameter int TIMEOUT_CYC = RSP_TIMEOUT_CYC
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // serial link
    mbw_if.master link,
    // command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_rw_i,
    input wire logic [7:0] cmd_slave_i,
    input wire logic [1:0] cmd_type_i,
    input wire logic [13:0] cmd_wr_index_i,
    input wire logic [7:0] cmd_wr_params_i,
    input wire logic [13:0] cmd_rd_index_i,
    input wire logic [7:0] cmd_rd_params_i,
    // write data fetch
    output logic [7:0] wd_param_o,
    input wire logic [31:0] wd_data_i,
    // read data
    output logic rd_valid_o,
    output logic [31:0] rd_data_o,
    // completion
    output logic done_o,
    output logic done_ok_o,
    output logic done_timeout_o,
    output logic [7:0] done_exc_o,
    output logic [15:0] done_count_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0]
    {
        M_IDLE = 2'b00,
        M_SEND = 2'b01,
        M_WAIT = 2'b11
    } mbw_mst_e;

    typedef struct packed
    {
        mbw_mst_e st;
        logic rw;
        logic [7:0] slave;
        logic [1:0] typ;
        logic [13:0] wix;
        logic [7:0] wpar;
        logic [13:0] rix;
        logic [7:0] rpar;
        logic [8:0] bi;
        logic [7:0] k;
        logic [1:0] pos;
        logic [15:0] crc;
        logic req_valid;
        logic [7:0] req_data;
        logic req_end;
        logic [8:0] rcv;
        logic [7:0] rbc;
        logic exc_seen;
        logic [31:0] word;
        logic rd_valid;
        logic [31:0] rd_data;
        logic done;
        logic ok;
        logic tmo_flag;
        logic [7:0] exc;
        logic [15:0] cnt;
        logic [31:0] tmo;
    } mbw_mstate_s;

    mbw_mstate_s m_q;
    mbw_mstate_s m_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [RW_HDR-1:0][7:0] h;
        logic [15:0] wregs;
        logic [15:0] rregs;
        logic [15:0] wst;
        logic [15:0] rst;
        logic [7:0] bc;
        logic [8:0] hdr;
        logic [8:0] total;
        logic [1:0] plast;
        logic [1:0] sel;
        logic [31:0] sh;
        logic [7:0] b;
        logic wide;
        m_d = m_q;
        wide = mbw_wide(m_q.typ);
        plast = wide ? 2'h3 : 2'h1;
        // wide values count as two registers each
        wregs = wide ? {7'h00, m_q.wpar, 1'b0} : {8'h00, m_q.wpar};
        rregs = wide ? {7'h00, m_q.rpar, 1'b0} : {8'h00, m_q.rpar};
        wst = {m_q.typ, m_q.wix};
        rst = {m_q.typ, m_q.rix};
        bc = {wregs[6:0], 1'b0};
        hdr = m_q.rw ? 9'(RW_HDR) : 9'(WM_HDR);
        total = hdr + {1'b0, bc};
        h = '0;
        h[OFS_ADDR] = m_q.slave;
        h[OFS_FC] = m_q.rw ? FC_RWMULT : FC_WMULT;
        if (m_q.rw)
        begin
            h[OFS_START] = rst[15:8];
            h[OFS_START+1] = rst[7:0];
            h[OFS_CNT] = rregs[15:8];
            h[OFS_CNT+1] = rregs[7:0];
            h[OFS_WSTART] = wst[15:8];
            h[OFS_WSTART+1] = wst[7:0];
            h[OFS_WCNT] = wregs[15:8];
            h[OFS_WCNT+1] = wregs[7:0];
            h[OFS_RW_BC] = bc;
        end
        else
        begin
            h[OFS_START] = wst[15:8];
            h[OFS_START+1] = wst[7:0];
            h[OFS_CNT] = wregs[15:8];
            h[OFS_CNT+1] = wregs[7:0];
            h[OFS_WM_BC] = bc;
        end
        sel = plast - m_q.pos;
        sh = wd_data_i >> {sel, 3'b000};
        b = 8'h00;
        m_d.req_valid = 1'b0;
        m_d.req_end = 1'b0;
        m_d.rd_valid = 1'b0;
        m_d.done = 1'b0;
        unique case (m_q.st)
        M_IDLE:
        begin
            if (cmd_valid_i)
            begin
                m_d.rw = cmd_rw_i;
                m_d.slave = cmd_slave_i;
                m_d.typ = cmd_type_i;
                m_d.wix = cmd_wr_index_i;
                m_d.wpar = cmd_wr_params_i;
                m_d.rix = cmd_rd_index_i;
                m_d.rpar = cmd_rd_params_i;
                m_d.bi = '0;
                m_d.k = '0;
                m_d.pos = '0;
                m_d.crc = CRC_INIT;
                m_d.st = M_SEND;
            end
        end
        M_SEND:
        begin
            m_d.req_valid = 1'b1;
            m_d.bi = m_q.bi + 9'h001;
            if (m_q.bi < hdr)
                b = h[m_q.bi];
            else if (m_q.bi < total)
            begin
                b = sh[7:0]; // msw first, high byte first
                m_d.pos = (m_q.pos == plast) ? 2'h0 : m_q.pos + 2'h1;
                if (m_q.pos == plast)
                    m_d.k = m_q.k + 8'h01;
            end
            if (m_q.bi < total)
            begin
                m_d.req_data = b;
                m_d.crc = mbw_crc(m_q.crc, b);
            end
            else if (m_q.bi == total)
                m_d.req_data = m_q.crc[7:0];
            else if (m_q.bi == total + 9'h001)
                m_d.req_data = m_q.crc[15:8];
            else
            begin
                m_d.req_valid = 1'b0;
                m_d.req_end = 1'b1;
                m_d.crc = CRC_INIT;
                m_d.rcv = '0;
                m_d.pos = '0;
                m_d.tmo = '0;
                m_d.exc_seen = 1'b0;
                m_d.exc = EXC_NONE;
                m_d.cnt = '0;
                m_d.rbc = '0;
                // a broadcast gets no reply, so it completes here
                if (m_q.slave == MBW_BCAST)
                begin
                    m_d.done = 1'b1;
                    m_d.ok = 1'b1;
                    m_d.tmo_flag = 1'b0;
                    m_d.st = M_IDLE;
                end
                else
                    m_d.st = M_WAIT;
            end
        end
        M_WAIT:
        begin
            m_d.tmo = m_q.tmo + 32'h1;
            if (link.rsp_valid)
            begin
                m_d.crc = mbw_crc(m_q.crc, link.rsp_data);
                m_d.rcv = m_q.rcv + 9'h001;
                if (m_q.rcv == 9'(OFS_FC))
                    m_d.exc_seen = link.rsp_data[7];
                if (m_q.rcv == 9'(RSP_BC))
                begin
                    m_d.rbc = link.rsp_data;
                    if (m_q.exc_seen)
                        m_d.exc = link.rsp_data;
                end
                if (!m_q.rw && m_q.rcv == 9'(OFS_CNT))
                    m_d.cnt[15:8] = link.rsp_data;
                if (!m_q.rw && m_q.rcv == 9'(OFS_CNT + 1))
                    m_d.cnt[7:0] = link.rsp_data;
                if (m_q.rw && !m_q.exc_seen && m_q.rcv >= 9'(RSP_HDR)
                    && m_q.rcv < 9'(RSP_HDR) + {1'b0, m_q.rbc})
                begin
                    m_d.word = {m_q.word[23:0], link.rsp_data};
                    m_d.pos = (m_q.pos == plast) ? 2'h0 : m_q.pos + 2'h1;
                    if (m_q.pos == plast)
                    begin
                        m_d.rd_valid = 1'b1;
                        m_d.rd_data = wide ? {m_q.word[23:0], link.rsp_data}
                            : {16'h0000, m_q.word[7:0], link.rsp_data};
                    end
                end
            end
            if (link.rsp_end)
            begin
                m_d.done = 1'b1;
                m_d.ok = m_q.crc == CRC_GOOD && !m_q.exc_seen;
                m_d.tmo_flag = 1'b0;
                m_d.st = M_IDLE;
            end
            else if (m_q.tmo == 32'(TIMEOUT_CYC - 1))
            begin
                // a dropped request is only ever seen as silence
                m_d.done = 1'b1;
                m_d.ok = 1'b0;
                m_d.tmo_flag = 1'b1;
                m_d.st = M_IDLE;
            end
        end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            m_q <= '0;
        else
            m_q <= m_d;
    end

    assign link.req_valid = m_q.req_valid;
    assign link.req_data = m_q.req_data;
    assign link.req_end = m_q.req_end;
    assign cmd_ready_o = m_q.st == M_IDLE;
    assign wd_param_o = m_q.k;
    assign rd_valid_o = m_q.rd_valid;
    assign rd_data_o = m_q.rd_data;
    assign done_o = m_q.done;
    assign done_ok_o = m_q.ok;
    assign done_timeout_o = m_q.tmo_flag;
    assign done_exc_o = m_q.exc;
    assign done_count_o = m_q.cnt;

endmodule

// file: bench/mbw_link_assertions.sv
// link checker for the master to slave byte stream
`timescale 1ns/1ps
module mbw_link_assertions
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // link
    input wire logic req_valid,
    input wire logic [7:0] req_data,
    input wire logic req_end,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_end
);
    logic [7:0] n_q, r_q, a_q, f_q, b_q;
    logic [15:0] qc_q, sc_q;
    logic qz, sz;
    assign qz = !rst_n_i || req_end;
    assign sz = !rst_n_i || rsp_end;
    ////////////////////////////////////////////////////////////////////////
    // own copy of the check so a shared slip cannot hide itself
    function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        return c;
    endfunction
    always_ff @(posedge core_clk_i)
    begin
        n_q <= qz ? 8'h00 : n_q + 8'(req_valid);
        r_q <= sz ? 8'h00 : r_q + 8'(rsp_valid);
        qc_q <= qz ? 16'hffff : req_valid ? crc(qc_q, req_data) : qc_q;
        sc_q <= sz ? 16'hffff : rsp_valid ? crc(sc_q, rsp_data) : sc_q;
        if (req_valid && n_q == 8'h00) a_q <= req_data;
        if (req_valid && n_q == 8'h01) f_q <= req_data;
        if (rsp_valid && r_q == 8'h02) b_q <= rsp_data;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_last;
        rsp_valid ##1 !rsp_valid;
    endsequence
    sequence s_first;
        rsp_valid && r_q == 8'h00;
    endsequence
    a_end_alone: assert property (req_end |-> !req_valid)
        else $error("request end with a byte");
    a_reply_tail: assert property (s_last |-> rsp_end)
        else $error("reply bytes not back to back");
    a_own_addr: assert property (s_first |-> rsp_data == a_q)
        else $error("reply address differs");
    a_no_bcast: assert property (s_first |-> a_q != 8'h00)
        else $error("reply to broadcast");
    a_func_echo: assert property (rsp_valid && r_q == 8'h01 |->
        rsp_data == f_q || rsp_data == (f_q | 8'h80))
        else $error("reply function wrong");
    a_req_crc: assert property (req_end |-> qc_q == 16'h0000)
        else $error("request check bad");
    a_rsp_crc: assert property (rsp_end |-> sc_q == 16'h0000)
        else $error("reply check bad");
    a_reply_len: assert property (rsp_end |-> r_q == 8'h05 ||
        (f_q == 8'h10 ? r_q == 8'h08 : r_q == b_q + 8'h05))
        else $error("reply length wrong");
endmodule

// file: bench/modbus_rtu_block_write_type_select_bench.sv
// bench: master and slave ends joined, compared with a queue model
`timescale 1ns/1ps
module modbus_rtu_block_write_type_select_bench
    import mbw_pkg::*;
;
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, m); end end
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, cv = 1'b0, rw = 1'b0, ok = 1'b1;
    logic [7:0] sa = 8'h00, wn = 8'h00, rn = 8'h00, wp, dex;
    logic [1:0] ty = 2'b00, wt, rt;
    logic [13:0] wx, rx;
    logic [31:0] wd = 32'h00000000, rd = 32'h00000000, od, rdo, v;
    logic [31:0] mem [64], em [64], wdat [16];
    logic wv, rv, dn, dok, dto, cr;
    logic [15:0] dcnt, lf = 16'h004e;
    logic [47:0] wq [$];
    logic [31:0] rq [$];
    int err_total = 0, n_checks = 0;
    mbw_if link ();
    mbw_master #(.TIMEOUT_CYC(200)) mbw_master_inst (.core_clk_i, .rst_n_i,
        .link(link), .cmd_valid_i(cv), .cmd_ready_o(cr), .cmd_rw_i(rw),
        .cmd_slave_i(sa), .cmd_type_i(ty), .cmd_wr_index_i(14'h0000),
        .cmd_wr_params_i(wn), .cmd_rd_index_i(14'h0020), .cmd_rd_params_i(rn),
        .wd_param_o(wp), .wd_data_i(wd), .rd_valid_o(rv), .rd_data_o(rdo),
        .done_o(dn), .done_ok_o(dok), .done_timeout_o(dto), .done_exc_o(dex),
        .done_count_o(dcnt));
    mbw_slave mbw_slave_inst (.core_clk_i, .rst_n_i, .link(link),
        .own_addr_i(8'h2a), .wr_valid_o(wv), .wr_index_o(wx), .wr_type_o(wt),
        .wr_data_o(od), .wr_ok_i(ok), .rd_index_o(rx), .rd_type_o(rt),
        .rd_data_i(rd));
    mbw_link_assertions mbw_link_assertions_inst (.core_clk_i, .rst_n_i,
        .req_valid(link.req_valid), .req_data(link.req_data),
        .req_end(link.req_end), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data), .rsp_end(link.rsp_end));
    initial forever #50 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////
    // user side storage; a low half of dead marks a value out of range
    always @(negedge core_clk_i)
    begin
        rd <= mem[rx[5:0]];
        wd <= wdat[wp[3:0]];
        ok <= od[15:0] != 16'hdead;
        if (wv && od[15:0] != 16'hdead) mem[wx[5:0]] <= od;
        if (wv) `CHK({wt, wx, od}, wq.pop_front(), "write")
        if (wv) `CHK(rt, ty, "read type")
        if (rv) `CHK(rdo, rq.pop_front(), "read")
    end
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run(logic r, logic [7:0] a, logic [1:0] t, int n, m, bad);
        int w, k, cyc;
        logic tmo, go;
        w = (t != 2'b00) ? 2 : 1;
        tmo = a != 8'h00 && (a != 8'h2a || n * w > 16);
        go = (a == 8'h2a || a == 8'h00) && n * w <= 16 && t != 2'b11;
        go = go && m * w <= 16;
        for (k = 0; k < n; k++)
        begin
            lf = lfsr(lf);
            v = {lf ^ 16'h5a5a, lf};
            if (k == bad) v[15:0] = 16'hdead;
            wdat[k] = v;
            if (w == 1) v = {{16{v[15]}}, v[15:0]};
            if (go && k <= bad) wq.push_back({t, 14'(k), v});
            if (go && k < bad) em[k] = v;
        end
        for (k = 0; go && !tmo && k < m; k++)
            rq.push_back(w == 2 ? em[32 + k] : {16'h0000, em[32 + k][15:0]});
        {cv, rw, sa, ty, wn, rn} <= {1'b1, r, a, t, 8'(n), 8'(m)};
        @(negedge core_clk_i);
        cv <= 1'b0;
        for (cyc = 0; cyc < 2000 && dn !== 1'b1; cyc++)
            @(negedge core_clk_i);
        `CHK(cyc < 2000, 1'b1, "no completion")
        if (cyc == 2000) stop_test();
        `CHK({dto, dok, dex & {8{!tmo}}}, {tmo, !tmo && t != 2'b11,
            (!tmo && t == 2'b11) ? EXC_ADDR : EXC_NONE}, "done")
        `CHK(cr, 1'b1, "not ready after done")
        if (!r && !tmo && t != 2'b11) `CHK(dcnt,
            16'(a == 8'h00 ? 0 : (bad < n ? bad : n) * w), "count")
        // a broadcast completes before the slave has written anything
        repeat (40) @(negedge core_clk_i);
        `CHK(wq.size() + rq.size(), 0, "missing transfers")
        $display("test done at %0t", $time);
    endtask
    initial
    begin
        for (int i = 0; i < 64; i++)
        begin
            mem[i] = {16'h0000, 16'(i * 1031)};
            em[i] = mem[i];
        end
        repeat (16) @(negedge core_clk_i);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        run(1'b0, 8'h2a, 2'b00, 3, 0, 99);
        run(1'b0, 8'h2a, 2'b01, 8, 0, 99);
        run(1'b0, 8'h2a, 2'b01, 9, 0, 99);
        run(1'b0, 8'h2a, 2'b00, 5, 0, 2);
        run(1'b0, 8'h00, 2'b00, 2, 0, 99);
        run(1'b0, 8'h2b, 2'b00, 2, 0, 99);
        run(1'b0, 8'h2a, 2'b11, 1, 0, 99);
        run(1'b0, 8'h2a, 2'b10, 2, 0, 99);
        run(1'b1, 8'h2a, 2'b00, 2, 4, 99);
        run(1'b1, 8'h2a, 2'b01, 2, 3, 99);
        run(1'b1, 8'h2a, 2'b01, 9, 1, 99);
        stop_test();
    end
endmodule
